//--- verilog/scrb_pkg.sv
// Purpose: shared constants for the synthesizer configuration bank and its serial host
// Assumes: 32-bit serial words, msb first, address in the low three bits
// Notes:   field positions are given as lsb plus width, single bits as an index; noise, factory and pump test widths set where used
package scrb_pkg;
   // word framing
   localparam int          WORD_W      = 32;
   localparam int          RW_BIT      = 31;           // 1 = read request
   localparam int          ADDR_W      = 3;
   localparam logic [2:0]  ADDR_R0     = 3'h0;
   localparam logic [2:0]  ADDR_R1     = 3'h1;
   localparam logic [2:0]  ADDR_R2     = 3'h2;
   localparam logic [2:0]  ADDR_R3     = 3'h3;
   // reset words
   localparam logic [31:0] R0_RST      = 32'h383c0000;
   localparam logic [31:0] R1_RST      = 32'h00000001;
   localparam logic [31:0] R2_RST      = 32'h0000fffa;
   localparam logic [31:0] R3_RST      = 32'h00000043;
   // register 0 fields
   localparam int          NLO_LSB     = 15;
   localparam int          NLO_W       = 12;
   localparam int          FRAC_LSB    = 3;
   localparam int          FRAC_W      = 12;
   // divider_prescale_phase fields
   localparam int          NHI_LSB     = 27;
   localparam int          NHI_W       = 4;
   localparam int          PRE_BIT     = 25;
   localparam int          RHI_LSB     = 15;
   localparam int          RHALF_W     = 5;
   localparam int          PHASE_LSB   = 3;
   localparam int          PHASE_W     = 12;
   // modulator_pump_reference fields
   localparam int          NOISE_LSB   = 29;
   localparam int          SLIP_BIT    = 28;
   localparam int          PUMP_LSB    = 24;
   localparam int          PUMP_W      = 4;
   localparam int          FACT_LSB    = 22;          // factory bits, must be 00
   localparam int          HALVE_BIT   = 21;
   localparam int          DOUBLE_BIT  = 20;
   localparam int          RLO_LSB     = 15;
   localparam int          MOD_LSB     = 3;
   localparam int          MOD_W       = 12;
   // pump_test_modulator_ctl fields
   localparam int          AUTOINT_BIT = 17;
   localparam int          PTEST_LSB   = 15;
   localparam int          RESTART_BIT = 14;          // 0 = restart modulator on reg 0 write
   // host register map (byte addresses)
   localparam logic [7:0]  HOST_CMD    = 8'h00;
   localparam logic [7:0]  HOST_STATUS = 8'h04;
   localparam logic [7:0]  HOST_RDATA  = 8'h08;
   localparam int          ST_BUSY     = 0;
   localparam int          ST_RVALID   = 1;

   // field extraction, right-justified
   function automatic logic [31:0] scrb_field(input logic [31:0] w, input int lsb, input int wd);
      scrb_field = (w >> lsb) & ((32'h1 << wd) - 32'h1);
   endfunction

   // active double-buffered values right after reset
   localparam logic [9:0]  REF_DIV_RST = {R1_RST[RHI_LSB +: RHALF_W], R2_RST[RLO_LSB +: RHALF_W]};
   localparam logic [11:0] MOD_RST     = R2_RST[MOD_LSB +: MOD_W];
endpackage

//--- verilog/scrb_link_if.sv
// Purpose: four-wire serial link between host and configuration bank
// Assumes: host drives clock, data and load; bank drives readback data
// Notes:   all four wires are plain one-way levels
`timescale 1ns/1ps
interface scrb_link_if;
   logic ser_clk;   // serial clock from host
   logic ser_data;  // word data, msb first
   logic ser_load;  // load strobe, word taken on rise
   logic ser_rdata; // readback data from bank
   modport device (input ser_clk, input ser_data, input ser_load, output ser_rdata);
   modport host   (output ser_clk, output ser_data, output ser_load, input ser_rdata);
endinterface

//--- verilog/scrb_device.sv
// Purpose: configuration register bank of the synthesizer, serial-loaded
// Assumes: serial pins are asynchronous to ref_clk and are synchronised here
// Notes:   pending reference and modulus fields commit on a register 0 write
`timescale 1ns/1ps
module scrb_device
   import scrb_pkg::*;
(
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        reset,
   // serial link
   scrb_link_if.device      link,
   // integer and fractional setting
   output logic [15:0]      int_div,
   output logic [11:0]      frac_value,
   output logic [11:0]      phase_value,
   output logic             prescale_div2,
   output logic             integer_mode,
   // double-buffered, active values
   output logic [9:0]       ref_div,
   output logic             ref_halve_en,
   output logic             ref_double_en,
   output logic [11:0]      modulus,
   // modulator and pump
   output logic [1:0]       modulator_noise_sel,
   output logic             slip_limit_en,
   output logic [3:0]       pump_current_code,
   output logic [1:0]       pump_test_sel,
   output logic             modulator_restart,
   output logic             commit_pulse
);
   // whole module state
   typedef struct packed {
      logic [1:0]  clk_s;     // clock synchroniser
      logic [1:0]  dat_s;     // data synchroniser
      logic [1:0]  ld_s;      // load synchroniser
      logic        clk_d;     // previous synced clock
      logic        ld_d;      // previous synced load
      logic [31:0] sh;        // incoming word
      logic [31:0] rd;        // outgoing readback word
      logic        sdo;       // readback pin
      logic [31:0] r0;        // register 0 image
      logic [31:0] r1;        // divider_prescale_phase
      logic [31:0] r2;        // modulator_pump_reference
      logic [31:0] r3;        // pump_test_modulator_ctl
      logic [9:0]  ref_a;     // active reference divide
      logic        halve_a;   // active halver
      logic        double_a;  // active doubler
      logic [11:0] mod_a;     // active modulus
      logic [15:0] n;         // output copies below
      logic [11:0] f;
      logic [11:0] p;
      logic        pre;
      logic        imode;
      logic [1:0]  noise;
      logic        slip;
      logic [3:0]  pump;
      logic [1:0]  ptest;
      logic        restart;
      logic        commit;
   } scrb_dev_state_t;

   scrb_dev_state_t st_reg;  // registered state
   scrb_dev_state_t st_next; // next state

   // next-state logic
   always_comb begin
      logic        clk_rise;
      logic        clk_fall;
      logic        ld_rise;
      logic [2:0]  addr;
      logic        wr0;
      clk_rise = 1'b0;
      clk_fall = 1'b0;
      ld_rise  = 1'b0;
      addr     = '0;
      wr0      = 1'b0;
      st_next  = st_reg;
      // the link pins come from another part with no clock relation to ours,
      // so each passes two flops; only the second stage feeds logic
      st_next.clk_s = {st_reg.clk_s[0], link.ser_clk};
      st_next.dat_s = {st_reg.dat_s[0], link.ser_data};
      st_next.ld_s  = {st_reg.ld_s[0], link.ser_load};
      st_next.clk_d = st_reg.clk_s[1];
      st_next.ld_d  = st_reg.ld_s[1];
      clk_rise = st_reg.clk_s[1] & ~st_reg.clk_d;
      clk_fall = ~st_reg.clk_s[1] & st_reg.clk_d;
      ld_rise  = st_reg.ld_s[1] & ~st_reg.ld_d;
      st_next.restart = 1'b0;
      st_next.commit  = 1'b0;
      // shift in msb first while load is low
      // clock edges seen while load is high belong to no word and are dropped
      if (clk_rise && !st_reg.ld_s[1]) begin
         st_next.sh = {st_reg.sh[30:0], st_reg.dat_s[1]};
      end
      // readback leaves msb first on each falling clock
      if (clk_fall) begin
         st_next.rd = {st_reg.rd[30:0], 1'b0};
      end
      // word complete on load rise
      if (ld_rise) begin
         addr = st_reg.sh[ADDR_W-1:0];
         if (st_reg.sh[RW_BIT]) begin
            // read: present the addressed word, unmapped reads as address only
            case (addr)
               ADDR_R0: st_next.rd = st_reg.r0;
               ADDR_R1: st_next.rd = st_reg.r1;
               ADDR_R2: st_next.rd = st_reg.r2;
               ADDR_R3: st_next.rd = st_reg.r3;
               default: st_next.rd = 32'(addr);
            endcase
         end else begin
            // write: stores whole word; factory bits kept as written, host keeps them zero
            case (addr)
               ADDR_R0: begin
                  st_next.r0 = st_reg.sh;
                  wr0        = 1'b1;
               end
               ADDR_R1: st_next.r1 = st_reg.sh;
               ADDR_R2: st_next.r2 = st_reg.sh;
               ADDR_R3: st_next.r3 = st_reg.sh;
               default: ;                                      // other addresses live elsewhere
            endcase
         end
      end
      // commit all pending fields in one cycle so the divider never sees a mix
      // the pending values are read from the images before this write lands,
      // which is right because register 0 holds none of them
      if (wr0) begin
         st_next.ref_a    = {10'(scrb_field(st_reg.r1, RHI_LSB, RHALF_W) << RHALF_W)}
                          | 10'(scrb_field(st_reg.r2, RLO_LSB, RHALF_W));
         st_next.halve_a  = st_reg.r2[HALVE_BIT];
         st_next.double_a = st_reg.r2[DOUBLE_BIT];
         st_next.mod_a    = 12'(scrb_field(st_reg.r2, MOD_LSB, MOD_W));
         st_next.commit   = 1'b1;
         st_next.restart  = ~st_reg.r3[RESTART_BIT];
      end
      // unbuffered fields follow the register images
      st_next.n     = {4'(scrb_field(st_reg.r1, NHI_LSB, NHI_W)),
                       12'(scrb_field(st_reg.r0, NLO_LSB, NLO_W))};
      st_next.f     = 12'(scrb_field(st_reg.r0, FRAC_LSB, FRAC_W));
      st_next.p     = 12'(scrb_field(st_reg.r1, PHASE_LSB, PHASE_W));
      st_next.pre   = st_reg.r1[PRE_BIT];
      st_next.noise = 2'(scrb_field(st_reg.r2, NOISE_LSB, 2));
      st_next.slip  = st_reg.r2[SLIP_BIT];
      st_next.pump  = 4'(scrb_field(st_reg.r2, PUMP_LSB, PUMP_W));
      st_next.ptest = 2'(scrb_field(st_reg.r3, PTEST_LSB, 2));
      // zero fraction forces integer mode only when enabled
      st_next.imode = st_reg.r3[AUTOINT_BIT]
                    && (scrb_field(st_reg.r0, FRAC_LSB, FRAC_W) == 32'h0);
      st_next.sdo   = st_reg.rd[RW_BIT];
   end

   // state register, synchronous reset to the documented defaults
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         st_reg          <= '0;
         st_reg.r0       <= R0_RST;
         st_reg.r1       <= R1_RST;
         st_reg.r2       <= R2_RST;
         st_reg.r3       <= R3_RST;
         st_reg.ref_a    <= REF_DIV_RST;
         st_reg.halve_a  <= R2_RST[HALVE_BIT];
         st_reg.double_a <= R2_RST[DOUBLE_BIT];
         st_reg.mod_a    <= MOD_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   // outputs come straight from the state flops
   // derived fields lag the images by one cycle; commit and restart come a cycle earlier, with the images
   assign link.ser_rdata        = st_reg.sdo;
   assign int_div               = st_reg.n;
   assign frac_value            = st_reg.f;
   assign phase_value           = st_reg.p;
   assign prescale_div2         = st_reg.pre;
   assign integer_mode          = st_reg.imode;
   assign ref_div               = st_reg.ref_a;
   assign ref_halve_en          = st_reg.halve_a;
   assign ref_double_en         = st_reg.double_a;
   assign modulus               = st_reg.mod_a;
   assign modulator_noise_sel   = st_reg.noise;
   assign slip_limit_en         = st_reg.slip;
   assign pump_current_code     = st_reg.pump;
   assign pump_test_sel         = st_reg.ptest;
   assign modulator_restart     = st_reg.restart;
   assign commit_pulse          = st_reg.commit;
endmodule

//--- verilog/scrb_host.sv
// Purpose: serial host for the configuration bank, commanded over APB
// Assumes: software writes a full 32-bit word; bit 31 marks a read request
// Notes:   serial clock is ref_clk divided; half period is a parameter
// Rules kept here: word framing built by software
`timescale 1ns/1ps
module scrb_host
   import scrb_pkg::*;
#(
   parameter int HALF_CYC = 8   // ref_clk cycles per serial half period, at least 6
)(
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        reset,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // serial link
   scrb_link_if.host        link
);
   typedef enum logic [2:0] {S_IDLE, S_LO, S_HI, S_LOAD, S_RLO, S_RHI} scrb_hstate_t;

   typedef struct packed {
      scrb_hstate_t fsm;   // transfer phase
      logic [15:0]  cnt;   // half-period counter
      logic [5:0]   bitn;  // bits done
      logic [31:0]  sh;    // outgoing word
      logic [31:0]  rx;    // readback word
      logic         rd;    // current word is a read
      logic         rvalid;
      logic [1:0]   sdo_s; // readback synchroniser
      logic         sclk;
      logic         sdi;
      logic         ld;
      logic [31:0]  prdata;
      logic         pready;
      logic         pslverr;
   } scrb_host_state_t;

   scrb_host_state_t st_reg; // registered state
   scrb_host_state_t st_next;

   localparam logic [15:0] HALF_LAST = 16'(HALF_CYC - 1);
   localparam logic [5:0]  LAST_BIT  = 6'(WORD_W - 1);
   localparam int          FACT_W    = 2;                 // width of the factory-only field

   // next-state logic
   always_comb begin
      logic half_done;
      logic acc;
      half_done = 1'b0;
      acc       = 1'b0;
      st_next   = st_reg;
      st_next.sdo_s = {st_reg.sdo_s[0], link.ser_rdata};
      half_done = (st_reg.cnt == HALF_LAST);
      st_next.cnt = half_done ? 16'h0 : st_reg.cnt + 16'h1;
      // apb: no wait state, answer ready in first access cycle
      st_next.pready  = psel & ~penable;
      st_next.pslverr = 1'b0;
      if (psel && !penable) begin
         case (paddr)
            HOST_CMD:    st_next.prdata = st_reg.sh;
            HOST_STATUS: st_next.prdata = 32'({st_reg.rvalid, st_reg.fsm != S_IDLE});
            HOST_RDATA:  st_next.prdata = st_reg.rx;
            default: begin
               st_next.prdata  = 32'h0;
               st_next.pslverr = 1'b1;
            end
         endcase
      end
      acc = psel & penable & st_reg.pready & pwrite & (paddr == HOST_CMD);
      case (st_reg.fsm)
         S_IDLE: begin
            // a command while busy is ignored, so idle is the only taker
            if (acc) begin
               st_next.sh     = pwdata;
               // factory bits of a modulator_pump_reference write always go out as zero
               if (!pwdata[RW_BIT] && (pwdata[ADDR_W-1:0] == ADDR_R2)) begin
                  st_next.sh[FACT_LSB +: FACT_W] = '0;
               end
               st_next.rd     = pwdata[RW_BIT];
               st_next.rvalid = 1'b0;
               st_next.bitn   = '0;
               st_next.cnt    = '0;
               st_next.sdi    = pwdata[RW_BIT];
               st_next.fsm    = S_LO;
            end
         end
         S_LO: if (half_done) begin
            st_next.sclk = 1'b1;
            st_next.fsm  = S_HI;
         end
         S_HI: if (half_done) begin
            st_next.sclk = 1'b0;
            st_next.sh   = {st_reg.sh[30:0], 1'b0};
            st_next.sdi  = st_reg.sh[30];
            st_next.bitn = st_reg.bitn + 6'h1;
            if (st_reg.bitn == LAST_BIT) begin
               st_next.ld  = 1'b1;
               st_next.fsm = S_LOAD;
            end else begin
               st_next.fsm = S_LO;
            end
         end
         S_LOAD: if (half_done) begin
            st_next.ld   = 1'b0;
            st_next.sdi  = 1'b0;
            st_next.bitn = '0;
            st_next.fsm  = st_reg.rd ? S_RLO : S_IDLE;
         end
         S_RLO: if (half_done) begin
            st_next.sclk = 1'b1;
            st_next.fsm  = S_RHI;
         end
         S_RHI: if (half_done) begin
            // sample at end of high half, data settled since the previous fall
            st_next.sclk = 1'b0;
            st_next.rx   = {st_reg.rx[30:0], st_reg.sdo_s[1]};
            st_next.bitn = st_reg.bitn + 6'h1;
            if (st_reg.bitn == LAST_BIT) begin
               st_next.rvalid = 1'b1;
               st_next.fsm    = S_IDLE;
            end else begin
               st_next.fsm = S_RLO;
            end
         end
         default: st_next.fsm = S_IDLE;
      endcase
   end

   // state register
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         st_reg     <= '0;
         st_reg.fsm <= S_IDLE;
      end else begin
         st_reg <= st_next;
      end
   end

   assign prdata        = st_reg.prdata;
   assign pready        = st_reg.pready;
   assign pslverr       = st_reg.pslverr;
   assign link.ser_clk  = st_reg.sclk;
   assign link.ser_data = st_reg.sdi;
   assign link.ser_load = st_reg.ld;
endmodule

//--- tb/scrb_chk_sva.sv
// Purpose: protocol checker for the serial link between host and bank
// Assumes: host built with a serial half period of 6 ref_clk cycles
// Notes:   watches the four link wires only, both ends are design code
`timescale 1ns/1ps
module scrb_chk (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // serial link
   input wire logic ser_clk,
   input wire logic ser_data,
   input wire logic ser_load,
   input wire logic ser_rdata
);
   // helper state, one packed struct
   typedef struct packed {
      logic [6:0]  rises;   // serial clock rises since last load
      logic [31:0] shift;   // last bits seen on ser_data
      logic        rd_pend; // last loaded word asked for readback
      logic        clk_d;   // ser_clk one cycle back
      logic        load_d;  // ser_load one cycle back
   } scrb_chk_st_t;
   scrb_chk_st_t st_reg;
   scrb_chk_st_t st_next;

   // count clock rises per frame; a read frame carries 32 readback clocks
   always_comb begin
      st_next = st_reg;
      st_next.clk_d = ser_clk;
      st_next.load_d = ser_load;
      if (ser_clk && !st_reg.clk_d) begin
         st_next.rises = st_reg.rises + 7'd1;
         st_next.shift = {st_reg.shift[30:0], ser_data};
      end
      if (ser_load && !st_reg.load_d) begin
         st_next.rises = 7'd0;
         st_next.rd_pend = st_reg.shift[31];
      end
   end

   // register the helper state
   always_ff @(posedge ref_clk) begin
      if (reset) st_reg <= '0;
      else st_reg <= st_next;
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   chk_word_count: assert property ($rose(ser_load) |->
      st_reg.rises == (st_reg.rd_pend ? 7'd64 : 7'd32)) else $error("bad clock count per word");
   chk_clk_high_half: assert property ($rose(ser_clk) |-> ser_clk[*6])
      else $error("serial clock high half too short");
   chk_clk_low_half: assert property ($fell(ser_clk) |-> (!ser_clk)[*6])
      else $error("serial clock low half too short");
   chk_data_steady: assert property (ser_clk && $past(ser_clk) |-> $stable(ser_data))
      else $error("data moved while serial clock high");
   chk_load_clk_apart: assert property (ser_load |-> !ser_clk)
      else $error("serial clock high during load");
   chk_load_width: assert property ($rose(ser_load) |-> ser_load[*6] ##1 !ser_load)
      else $error("load strobe width wrong");
   chk_read_tail: assert property (st_reg.rd_pend && st_reg.rises < 7'd32 && $rose(ser_clk)
      |-> !ser_data) else $error("data not low during readback");
   chk_reset_quiet: assert property (disable iff (1'b0) reset |=>
      !ser_clk && !ser_load && !ser_rdata) else $error("link not idle in reset");

   // main scenarios
   cov_write_word: cover property ($rose(ser_load) && !st_next.rd_pend);
   cov_read_word: cover property ($rose(ser_load) && st_next.rd_pend);
   cov_read_bit: cover property (st_reg.rd_pend && $rose(ser_clk) && ser_rdata);
endmodule

//--- tb/tb_synth_config_register_bank.sv
// Purpose: self-checking bench for the bank and its serial host
// Assumes: host half period of 6 cycles keeps words short
// Notes:   model keeps register images and active buffered values
`timescale 1ns/1ps
module tb_synth_config_register_bank;
   import scrb_pkg::*;
   logic        ref_clk = 1'b0;  // 50 MHz
   logic        reset   = 1'b1;  // sync, active high
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
   logic [7:0]  paddr  = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [15:0] int_div;
   logic [11:0] frac_value, phase_value, modulus;
   logic [9:0]  ref_div;
   logic [3:0]  pump_current_code;
   logic [1:0]  modulator_noise_sel, pump_test_sel;
   logic        prescale_div2, integer_mode, ref_halve_en, ref_double_en, slip_limit_en;
   logic        modulator_restart, commit_pulse;
   // model: register images and active buffered values
   logic [31:0] img [4]  = '{R0_RST, R1_RST, R2_RST, R3_RST};
   logic [9:0]  m_ref    = {R1_RST[19:15], R2_RST[19:15]};
   logic [11:0] m_mod    = R2_RST[14:3];
   logic        m_halve  = R2_RST[21], m_double = R2_RST[20];
   logic [31:0] rng      = 32'h0000004d; // xorshift seed 77
   int          num_errors = 0, n_checks = 0, n_commit = 0, n_restart = 0, e_commit = 0;
   int          e_restart  = 0;

   scrb_link_if link ();
   scrb_host #(.HALF_CYC(6)) i_scrb_host (.ref_clk(ref_clk), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .link(link));
   scrb_device i_scrb_device (.ref_clk(ref_clk), .reset(reset), .link(link),
      .int_div(int_div), .frac_value(frac_value), .phase_value(phase_value),
      .prescale_div2(prescale_div2), .integer_mode(integer_mode), .ref_div(ref_div),
      .ref_halve_en(ref_halve_en), .ref_double_en(ref_double_en), .modulus(modulus),
      .modulator_noise_sel(modulator_noise_sel), .slip_limit_en(slip_limit_en),
      .pump_current_code(pump_current_code), .pump_test_sel(pump_test_sel),
      .modulator_restart(modulator_restart), .commit_pulse(commit_pulse));
   scrb_chk i_scrb_chk (.ref_clk(ref_clk), .reset(reset), .ser_clk(link.ser_clk),
      .ser_data(link.ser_data), .ser_load(link.ser_load), .ser_rdata(link.ser_rdata));

   // clock, 20 ns period
   always #10 ref_clk = ~ref_clk;

   // count one-cycle pulses so that a missing or doubled pulse shows
   always @(posedge ref_clk) begin
      if (commit_pulse === 1'b1) n_commit <= n_commit + 1;
      if (modulator_restart === 1'b1) n_restart <= n_restart + 1;
   end

   function automatic logic [31:0] xorshift(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   // closing report, the only exit
   task automatic end_sim();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // compare one value, x never matches
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // one apb transfer; request held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         num_errors++;
         end_sim();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // every device output but the two pulses against the model
   task automatic check_outputs();
      chk(int_div, {img[1][30:27], img[0][26:15]});
      chk(frac_value, img[0][14:3]);
      chk(phase_value, img[1][14:3]);
      chk(prescale_div2, img[1][25]);
      chk(integer_mode, img[3][17] && img[0][14:3] == 12'h000);
      chk({ref_div, ref_halve_en, ref_double_en, modulus}, {m_ref, m_halve, m_double, m_mod});
      chk({modulator_noise_sel, slip_limit_en, pump_current_code}, img[2][30:24]);
      chk(pump_test_sel, img[3][16:15]);
   endtask

   // send one word, wait for busy to clear, update the model
   task automatic send(input logic [31:0] w);
      int n;
      apb(1'b1, HOST_CMD, w);
      n = 0;
      do begin
         apb(1'b0, HOST_STATUS, 32'h0);
         n++;
      end while (rd[ST_BUSY] !== 1'b0 && n < 1000);
      if (n >= 1000) begin
         num_errors++;
         end_sim();
      end
      repeat (4) @(posedge ref_clk);
      if (!w[31] && w[2:0] < 3'h4) begin
         img[w[1:0]] = w;
         if (w[2:0] == ADDR_R2) img[2][FACT_LSB +: 2] = 2'b00;
         // only a register 0 write moves the buffered values, all at once
         if (w[2:0] == ADDR_R0) begin
            m_ref = {img[1][19:15], img[2][19:15]};
            m_halve = img[2][21];
            m_double = img[2][20];
            m_mod = img[2][14:3];
            e_commit++;
            if (!img[3][RESTART_BIT]) e_restart++;
         end
      end
      check_outputs();
   endtask

   // read one register over the link
   task automatic read_back(input logic [2:0] a);
      send({1'b1, 28'h0, a});
      apb(1'b0, HOST_RDATA, 32'h0);
      chk(rd, (a < 3'h4) ? img[a[1:0]] : {29'h0, a});
      apb(1'b0, HOST_STATUS, 32'h0);
      chk(rd[ST_RVALID], 1'b1);
   endtask

   initial begin
      repeat (3) @(posedge ref_clk);
      reset <= 1'b0;
      repeat (3) @(posedge ref_clk);
      check_outputs();
      for (int a = 0; a < 8; a++) read_back(a[2:0]);
      apb(1'b1, 8'h0c, 32'h1);
      chk({err, rd}, {1'b1, 32'h0});
      // every noise and pump test code, restart on and off, zero fraction last
      for (int k = 0; k < 4; k++) begin
         rng = xorshift(rng);
         send((rng & 32'h7a0ffff8) | 32'h1);
         rng = xorshift(rng);
         send((rng & 32'h1ffffff8) | {1'b0, k[1:0], 29'h0} | 32'h8012);
         send({14'h0, k[1], k[1:0], k[0], 11'h0, 3'h3});
         rng = xorshift(rng);
         send(k == 3 ? 32'h00780000 : ((rng & 32'h7fff8000)
              | {17'h0, 12'(rng[14:3] % img[2][14:3]), 3'h0}));
         read_back(3'h2);
      end
      chk(n_commit, e_commit);
      chk(n_restart, e_restart);
      end_sim();
   end
endmodule
